/* hdl/cmu_pkg.sv */
// Constants, register map and state record of the compare match event unit.
// Assumes a 32-bit AXI4-Lite master and 16-bit timers ticking in CLK domain.
`default_nettype none

package cmu_pkg;

	localparam int NUM_UNITS        = 5;
	localparam int NUM_TIMERS       = 3;
	localparam int ADDR_W           = 8;
	localparam int REG_W            = 8;
	localparam int DATA_W           = 32;
	localparam int MATCH_W          = 16;
	localparam int ADC_UNIT         = 4;
	localparam int ALT_UNIT_A       = 1;
	localparam int ALT_UNIT_B       = 2;
	localparam int FIRST_SHORT_UNIT = 3;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MLOW   = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_MHIGH  = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_TSEL_A = 8'h60;
	localparam logic [ADDR_W-1:0] OFS_TSEL_B = 8'h64;
	localparam logic [ADDR_W-1:0] OFS_FLAGS  = 8'h68;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h6c;
	localparam logic [ADDR_W-1:0] BANK_SPAN  = 8'h14;

	// Field layout
	localparam int MODE_LSB = 0;
	localparam int MODE_W   = 4;
	localparam int TSEL_W   = 2;
	localparam int TSEL_LSB [NUM_UNITS] = '{0, 3, 6, 0, 2};

	localparam logic [REG_W-1:0] CTRL_MASK_FULL  = 8'hff;
	localparam logic [REG_W-1:0] CTRL_MASK_SHORT = 8'h3f;
	localparam logic [REG_W-1:0] TSEL_A_MASK     = 8'hdb;
	localparam logic [REG_W-1:0] TSEL_B_MASK     = 8'h0f;
	localparam logic [REG_W-1:0] REG_RESET       = 8'h00;

	// Compare mode codes
	localparam logic [MODE_W-1:0] MODE_TOGGLE  = 4'h2;
	localparam logic [MODE_W-1:0] MODE_SET     = 4'h8;
	localparam logic [MODE_W-1:0] MODE_CLEAR   = 4'h9;
	localparam logic [MODE_W-1:0] MODE_SWINT   = 4'ha;
	localparam logic [MODE_W-1:0] MODE_SPECIAL = 4'hb;

	localparam logic [TSEL_W-1:0] TSEL_RESERVED = 2'h3;
	localparam logic [TSEL_W-1:0] TSEL_DEFAULT  = 2'h0;
	localparam logic [1:0]        RESP_OKAY     = 2'h0;
	localparam logic [1:0]        RESP_SLVERR   = 2'h2;

	// Decoded register kinds
	localparam logic [2:0] K_CTRL   = 3'h0;
	localparam logic [2:0] K_MLOW   = 3'h1;
	localparam logic [2:0] K_MHIGH  = 3'h2;
	localparam logic [2:0] K_TSEL_A = 3'h3;
	localparam logic [2:0] K_TSEL_B = 3'h4;
	localparam logic [2:0] K_FLAGS  = 3'h5;
	localparam logic [2:0] K_STATUS = 3'h6;
	localparam logic [2:0] K_NONE   = 3'h7;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_RESP = 2'b01
	} cmu_wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_DATA = 2'b01
	} cmu_rd_state_t;

	typedef struct packed {
		logic [NUM_UNITS-1:0][REG_W-1:0] ctrl;
		logic [NUM_UNITS-1:0][REG_W-1:0] mlow;
		logic [NUM_UNITS-1:0][REG_W-1:0] mhigh;
		logic [REG_W-1:0]                tsel_a;
		logic [REG_W-1:0]                tsel_b;
		logic [NUM_UNITS-1:0]            flag;
		logic [NUM_UNITS-1:0]            out_latch;
		logic [NUM_UNITS-1:0]            eq_prev;
		logic [NUM_UNITS-1:0]            pending;
		logic [NUM_UNITS-1:0]            oe_pri;
		logic [1:0]                      oe_alt;
		logic [NUM_TIMERS-1:0]           tclear;
		logic                            conv_start;
		cmu_wr_state_t                   wr;
		logic                            aw_have;
		logic                            w_have;
		logic [ADDR_W-1:0]               awaddr;
		logic [REG_W-1:0]                wdata;
		logic                            wstrb0;
		logic                            awready;
		logic                            wready;
		logic                            bvalid;
		logic [1:0]                      bresp;
		cmu_rd_state_t                   rd;
		logic                            arready;
		logic                            rvalid;
		logic [DATA_W-1:0]               rdata;
		logic [1:0]                      rresp;
	} cmu_state_t;

	// Address to {kind, unit index}
	function automatic logic [5:0] cmu_decode(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d = 8'h00;
		cmu_decode = {K_NONE, 3'h0};
		if (a[1:0] != 2'b00) begin
			cmu_decode = {K_NONE, 3'h0};
		end else if (a < OFS_CTRL + BANK_SPAN) begin
			d = a - OFS_CTRL;
			cmu_decode = {K_CTRL, d[4:2]};
		end else if (a >= OFS_MLOW && a < OFS_MLOW + BANK_SPAN) begin
			d = a - OFS_MLOW;
			cmu_decode = {K_MLOW, d[4:2]};
		end else if (a >= OFS_MHIGH && a < OFS_MHIGH + BANK_SPAN) begin
			d = a - OFS_MHIGH;
			cmu_decode = {K_MHIGH, d[4:2]};
		end else if (a == OFS_TSEL_A) begin
			cmu_decode = {K_TSEL_A, 3'h0};
		end else if (a == OFS_TSEL_B) begin
			cmu_decode = {K_TSEL_B, 3'h0};
		end else if (a == OFS_FLAGS) begin
			cmu_decode = {K_FLAGS, 3'h0};
		end else if (a == OFS_STATUS) begin
			cmu_decode = {K_STATUS, 3'h0};
		end
	endfunction

endpackage

`default_nettype wire

/* hdl/cmu_top.sv */
// Compare match event unit: five compare channels over three timers.
// Assumes timers count in the CLK domain and mark each count with a tick.
`default_nettype none

module cmu_top
	import cmu_pkg::*;
(
	input  wire logic                               CLK,
	input  wire logic                               RESET_N,
	input  wire logic [ADDR_W-1:0]                  AWADDR,
	input  wire logic                               AWVALID,
	output logic                                    AWREADY,
	input  wire logic [DATA_W-1:0]                  WDATA,
	input  wire logic [DATA_W/8-1:0]                WSTRB,
	input  wire logic                               WVALID,
	output logic                                    WREADY,
	output logic [1:0]                              BRESP,
	output logic                                    BVALID,
	input  wire logic                               BREADY,
	input  wire logic [ADDR_W-1:0]                  ARADDR,
	input  wire logic                               ARVALID,
	output logic                                    ARREADY,
	output logic [DATA_W-1:0]                       RDATA,
	output logic [1:0]                              RRESP,
	output logic                                    RVALID,
	input  wire logic                               RREADY,
	input  wire logic [NUM_TIMERS-1:0][MATCH_W-1:0] TIMER_COUNT,
	input  wire logic [NUM_TIMERS-1:0]              TIMER_TICK,
	output logic [NUM_TIMERS-1:0]                   TIMER_CLEAR,
	input  wire logic                               CONV_ON,
	output logic                                    CONV_START,
	input  wire logic [1:0]                         PIN_SEL,
	output logic [NUM_UNITS-1:0]                    CMP_OUT,
	output logic [NUM_UNITS-1:0]                    CMP_OE_PRI,
	output logic [1:0]                              CMP_OE_ALT
);

	localparam cmu_state_t RESET_ST = '0;

	cmu_state_t                     st;
	cmu_state_t                     n;
	logic [NUM_UNITS-1:0]           eq;
	logic [NUM_UNITS-1:0]           hit;
	logic [NUM_UNITS-1:0]           act;
	logic [NUM_UNITS-1:0][1:0]      tsel;
	logic [NUM_UNITS-1:0][MODE_W-1:0] mode;
	logic [NUM_UNITS-1:0]           zero_wr;
	logic [NUM_UNITS-1:0]           match_wr;
	logic                           wr_fire;
	logic [2:0]                     wr_kind;
	logic [2:0]                     wr_idx;
	logic [REG_W-1:0]               wr_data;
	logic [2:0]                     rd_kind;
	logic [2:0]                     rd_idx;
	logic [REG_W-1:0]               rd_val;
	logic [NUM_UNITS-1:0]           flag_clr;

	function automatic logic [1:0] unit_tsel(input int u,
			input logic [REG_W-1:0] ra, input logic [REG_W-1:0] rb);
		logic [REG_W-1:0]  r;
		logic [TSEL_W-1:0] s;
		r = (u >= FIRST_SHORT_UNIT) ? rb : ra;
		s = r[TSEL_LSB[u] +: TSEL_W];
		unit_tsel = (s == TSEL_RESERVED) ? TSEL_DEFAULT : s;
	endfunction

	function automatic logic [REG_W-1:0] ctrl_mask(input logic [2:0] idx);
		ctrl_mask = (idx >= FIRST_SHORT_UNIT) ? CTRL_MASK_SHORT
		                                      : CTRL_MASK_FULL;
	endfunction

	function automatic logic is_compare(input logic [MODE_W-1:0] m);
		is_compare = (m == MODE_TOGGLE) || (m == MODE_SET) ||
		             (m == MODE_CLEAR) || (m == MODE_SWINT) ||
		             (m == MODE_SPECIAL);
	endfunction

	function automatic logic drives_pin(input logic [MODE_W-1:0] m);
		drives_pin = (m == MODE_TOGGLE) || (m == MODE_SET) ||
		             (m == MODE_CLEAR);
	endfunction

	genvar g;
	generate
		for (g = 0; g < NUM_UNITS; g++) begin : g_unit
			assign mode[g] = st.ctrl[g][MODE_LSB +: MODE_W];
			assign tsel[g] = unit_tsel(g, st.tsel_a, st.tsel_b);
			// Pair versus chosen timer, every cycle
			assign eq[g] = {st.mhigh[g], st.mlow[g]} ==
			               TIMER_COUNT[tsel[g]];
			assign hit[g] = eq[g] && !st.eq_prev[g];
			assign act[g] = hit[g] && is_compare(mode[g]);
			assign zero_wr[g] = wr_fire && wr_kind == K_CTRL &&
			                    wr_idx == 3'(g) && wr_data == REG_RESET;
			assign match_wr[g] = wr_fire && wr_idx == 3'(g) &&
			                     (wr_kind == K_MLOW || wr_kind == K_MHIGH);
		end
	endgenerate

	always_comb begin
		n        = st;
		n.conv_start = 1'b0;
		flag_clr = '0;
		wr_fire  = 1'b0;
		wr_kind  = K_NONE;
		wr_idx   = 3'h0;
		rd_kind  = K_NONE;
		rd_idx   = 3'h0;
		rd_val   = REG_RESET;

		// Write address and data may arrive in either order
		if (st.awready && AWVALID) begin
			n.aw_have = 1'b1;
			n.awaddr  = AWADDR;
		end
		if (st.wready && WVALID) begin
			n.w_have = 1'b1;
			n.wdata  = WDATA[REG_W-1:0];
			n.wstrb0 = WSTRB[0];
		end
		case (st.wr)
			WR_IDLE: begin
				if (n.aw_have && n.w_have) begin
					{wr_kind, wr_idx} = cmu_decode(n.awaddr);
					wr_fire   = n.wstrb0 && (wr_kind != K_NONE);
					n.bresp   = (wr_kind == K_NONE) ? RESP_SLVERR : RESP_OKAY;
					n.bvalid  = 1'b1;
					n.aw_have = 1'b0;
					n.w_have  = 1'b0;
					n.wr      = WR_RESP;
				end
			end
			WR_RESP: begin
				if (BREADY) begin
					n.bvalid = 1'b0;
					n.wr     = WR_IDLE;
				end
			end
			default: begin
				n.wr = WR_IDLE;
			end
		endcase
		wr_data = n.wdata;

		// Match events
		for (int u = 0; u < NUM_UNITS; u++) begin
			if (TIMER_TICK[tsel[u]]) begin
				n.pending[u] = 1'b0;
			end
			n.eq_prev[u] = eq[u];
			if (act[u]) begin
				case (mode[u])
					MODE_TOGGLE: begin
						n.out_latch[u] = !st.out_latch[u];
					end
					MODE_SET: begin
						n.out_latch[u] = 1'b1;
					end
					MODE_CLEAR: begin
						n.out_latch[u] = 1'b0;
					end
					MODE_SPECIAL: begin
						// Clear waits for the next tick
						n.pending[u] = 1'b1;
						if (u == ADC_UNIT && CONV_ON) begin
							n.conv_start = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end

		// Register writes
		if (wr_fire) begin
			if (wr_kind == K_CTRL) begin
				n.ctrl[wr_idx] = wr_data & ctrl_mask(wr_idx);
				if (wr_data == REG_RESET) begin
					n.out_latch[wr_idx] = 1'b0;
				end
			end else if (wr_kind == K_MLOW) begin
				n.mlow[wr_idx]    = wr_data;
				n.pending[wr_idx] = 1'b0;
			end else if (wr_kind == K_MHIGH) begin
				n.mhigh[wr_idx]   = wr_data;
				n.pending[wr_idx] = 1'b0;
			end else if (wr_kind == K_TSEL_A) begin
				n.tsel_a = wr_data & TSEL_A_MASK;
			end else if (wr_kind == K_TSEL_B) begin
				n.tsel_b = wr_data & TSEL_B_MASK;
			end else if (wr_kind == K_FLAGS) begin
				flag_clr = wr_data[NUM_UNITS-1:0];
			end
		end
		// Write-one-to-clear; a new match wins over the clear
		n.flag = (st.flag & ~flag_clr) | act;

		// Timer clear is a plain load request, overflow stays untouched
		n.tclear = '0;
		for (int u = 0; u < NUM_UNITS; u++) begin
			if (n.pending[u]) begin
				n.tclear[tsel[u]] = 1'b1;
			end
		end

		// Pin ownership only for pin-driving modes
		for (int u = 0; u < NUM_UNITS; u++) begin
			n.oe_pri[u] = drives_pin(n.ctrl[u][MODE_LSB +: MODE_W]);
		end
		n.oe_alt[0] = n.oe_pri[ALT_UNIT_A] && PIN_SEL[0];
		n.oe_alt[1] = n.oe_pri[ALT_UNIT_B] && PIN_SEL[1];
		n.oe_pri[ALT_UNIT_A] = n.oe_pri[ALT_UNIT_A] && !PIN_SEL[0];
		n.oe_pri[ALT_UNIT_B] = n.oe_pri[ALT_UNIT_B] && !PIN_SEL[1];

		// Read channel
		case (st.rd)
			RD_IDLE: begin
				if (st.arready && ARVALID) begin
					{rd_kind, rd_idx} = cmu_decode(ARADDR);
					if (rd_kind == K_CTRL) begin
						rd_val = st.ctrl[rd_idx];
					end else if (rd_kind == K_MLOW) begin
						rd_val = st.mlow[rd_idx];
					end else if (rd_kind == K_MHIGH) begin
						rd_val = st.mhigh[rd_idx];
					end else if (rd_kind == K_TSEL_A) begin
						rd_val = st.tsel_a;
					end else if (rd_kind == K_TSEL_B) begin
						rd_val = st.tsel_b;
					end else if (rd_kind == K_FLAGS) begin
						rd_val = {{(REG_W-NUM_UNITS){1'b0}}, st.flag};
					end else if (rd_kind == K_STATUS) begin
						rd_val = {{(REG_W-NUM_UNITS){1'b0}}, st.out_latch};
					end
					n.rdata  = {{(DATA_W-REG_W){1'b0}}, rd_val};
					n.rresp  = (rd_kind == K_NONE) ? RESP_SLVERR : RESP_OKAY;
					n.rvalid = 1'b1;
					n.rd     = RD_DATA;
				end
			end
			RD_DATA: begin
				if (RREADY) begin
					n.rvalid = 1'b0;
					n.rd     = RD_IDLE;
				end
			end
			default: begin
				n.rd = RD_IDLE;
			end
		endcase

		n.awready = !n.aw_have && (n.wr == WR_IDLE);
		n.wready  = !n.w_have && (n.wr == WR_IDLE);
		n.arready = (n.rd == RD_IDLE);
	end

	// Nothing advances while CLK is stopped
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			st <= RESET_ST;
		end else begin
			st <= n;
		end
	end

	assign AWREADY     = st.awready;
	assign WREADY      = st.wready;
	assign BRESP       = st.bresp;
	assign BVALID      = st.bvalid;
	assign ARREADY     = st.arready;
	assign RDATA       = st.rdata;
	assign RRESP       = st.rresp;
	assign RVALID      = st.rvalid;
	assign TIMER_CLEAR = st.tclear;
	assign CONV_START  = st.conv_start;
	assign CMP_OUT     = st.out_latch;
	assign CMP_OE_PRI  = st.oe_pri;
	assign CMP_OE_ALT  = st.oe_alt;

	generate
		for (g = 0; g < NUM_UNITS; g++) begin : g_chk
			property p_flag_on_match;
				@(posedge CLK) disable iff (!RESET_N)
				act[g] |=> st.flag[g];
			endproperty
			a_flag_on_match: assert property (p_flag_on_match)
				else $error("match flag not set");

			property p_toggle;
				@(posedge CLK) disable iff (!RESET_N)
				act[g] && mode[g] == MODE_TOGGLE && !zero_wr[g]
					|=> st.out_latch[g] != $past(st.out_latch[g]);
			endproperty
			a_toggle: assert property (p_toggle)
				else $error("toggle mode did not toggle");

			property p_set;
				@(posedge CLK) disable iff (!RESET_N)
				act[g] && mode[g] == MODE_SET && !zero_wr[g] |=> st.out_latch[g];
			endproperty
			a_set: assert property (p_set)
				else $error("set mode did not set output");

			property p_special_pin;
				@(posedge CLK) disable iff (!RESET_N)
				act[g] && mode[g] == MODE_SPECIAL && !zero_wr[g]
					|=> $stable(st.out_latch[g]);
			endproperty
			a_special_pin: assert property (p_special_pin)
				else $error("trigger mode moved output");

			property p_swint_pin;
				@(posedge CLK) disable iff (!RESET_N)
				mode[g] == MODE_SWINT |-> !st.oe_pri[g];
			endproperty
			a_swint_pin: assert property (p_swint_pin)
				else $error("software interrupt mode owns pin");

			property p_trigger_clears;
				@(posedge CLK) disable iff (!RESET_N)
				act[g] && mode[g] == MODE_SPECIAL && !match_wr[g]
					|=> TIMER_CLEAR[$past(tsel[g])];
			endproperty
			a_trigger_clears: assert property (p_trigger_clears)
				else $error("timer clear not requested");

			property p_lost;
				@(posedge CLK) disable iff (!RESET_N)
				match_wr[g] |=> !st.pending[g];
			endproperty
			a_lost: assert property (p_lost)
				else $error("clear kept after match rewrite");

			property p_once;
				@(posedge CLK) disable iff (!RESET_N)
				RESET_N && eq[g] ##1 eq[g] |-> !hit[g];
			endproperty
			a_once: assert property (p_once)
				else $error("match acted on twice");
		end
	endgenerate

	property p_conv;
		@(posedge CLK) disable iff (!RESET_N)
		act[ADC_UNIT] && mode[ADC_UNIT] == MODE_SPECIAL && CONV_ON
			|=> CONV_START ##1 !CONV_START;
	endproperty
	a_conv: assert property (p_conv)
		else $error("conversion start missing");

	property p_conv_gate;
		@(posedge CLK) disable iff (!RESET_N)
		CONV_START |-> $past(CONV_ON) && $past(act[ADC_UNIT]);
	endproperty
	a_conv_gate: assert property (p_conv_gate)
		else $error("conversion started without cause");

	property p_unimpl;
		@(posedge CLK) disable iff (!RESET_N)
		(st.ctrl[FIRST_SHORT_UNIT] & ~CTRL_MASK_SHORT) == REG_RESET &&
		(st.ctrl[ADC_UNIT] & ~CTRL_MASK_SHORT) == REG_RESET;
	endproperty
	a_unimpl: assert property (p_unimpl)
		else $error("unimplemented control bits set");

endmodule

`default_nettype wire

/* tb/cmu_timer_model.sv */
// Far side of the compare unit: three 16-bit timers and conversion starts.
// Assumes one CLK domain; each timer advances once every four CLK cycles.
`default_nettype none

module cmu_timer_model
	import cmu_pkg::*;
(
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	input  wire logic                          load,
	input  wire logic [MATCH_W-1:0]            load_val,
	input  wire logic [NUM_TIMERS-1:0]         hold,
	input  wire logic [NUM_TIMERS-1:0]         clear,
	input  wire logic                          conv_start,
	output logic [NUM_TIMERS-1:0][MATCH_W-1:0] count,
	output logic [NUM_TIMERS-1:0]              tick,
	output logic [NUM_TIMERS-1:0]              ovf,
	output int                                 conv_count
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] div;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			div <= 2'h0;
			tick <= '0;
			count <= '0;
			ovf <= '0;
			conv_count <= 0;
		end else begin
			div <= div + 2'h1;
			if (conv_start)
				conv_count <= conv_count + 1;
			for (int t = 0; t < NUM_TIMERS; t++) begin
				// Synchronous quarter-rate tick; hold stalls it
				tick[t] <= (div == 2'h3) && !hold[t];
				if (load) begin
					count[t] <= load_val;
					ovf[t] <= 1'b0;
				end else if (tick[t] && clear[t]) begin
					count[t] <= '0;
				end else if (tick[t]) begin
					count[t] <= count[t] + 16'h0001;
					if (count[t] == 16'hffff)
						ovf[t] <= 1'b1;
				end
			end
		end
	end
endmodule

`default_nettype wire

/* tb/cmu_bench.sv */
// Self-checking bench of the compare match event unit.
// Assumes cmu_timer_model on the timer side; register expectations queued.
`default_nettype none

module cmu_bench
	import cmu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                               CLK, RESET_N, CONV_ON, CONV_START;
	logic                               AWVALID, WVALID, BREADY, load;
	logic                               ARVALID, RREADY, AWREADY, WREADY;
	logic                               BVALID, ARREADY, RVALID;
	logic [ADDR_W-1:0]                  AWADDR, ARADDR;
	logic [DATA_W-1:0]                  WDATA, RDATA;
	logic [3:0]                         WSTRB;
	logic [1:0]                         BRESP, RRESP, PIN_SEL, CMP_OE_ALT;
	logic [NUM_TIMERS-1:0][MATCH_W-1:0] TIMER_COUNT;
	logic [NUM_TIMERS-1:0]              TIMER_TICK, TIMER_CLEAR, hold, ovf;
	logic [NUM_UNITS-1:0]               CMP_OUT, CMP_OE_PRI;
	logic [MATCH_W-1:0]                 load_val, m, peak;
	logic [33:0]                        rd_q [$];
	logic [1:0]                         wr_q [$];
	int                                 fail_count, compares, conv_count;
	int                                 base, i;
	logic [7:0] reg_a [4] = '{8'h00, 8'h0c, 8'h60, 8'h64};
	logic [7:0] reg_m [4] = '{8'hff, 8'h3f, 8'hdb, 8'h0f};
	logic [3:0] modes [5] = '{4'h2, 4'h9, 4'h8, 4'ha, 4'hb};
	logic       exp_out [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

	cmu_top dut (
		.CLK, .RESET_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
		.WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
		.ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .TIMER_COUNT,
		.TIMER_TICK, .TIMER_CLEAR, .CONV_ON, .CONV_START, .PIN_SEL,
		.CMP_OUT, .CMP_OE_PRI, .CMP_OE_ALT
	);

	cmu_timer_model far (
		.clk(CLK), .reset_n(RESET_N), .load, .load_val, .hold,
		.clear(TIMER_CLEAR), .conv_start(CONV_START), .count(TIMER_COUNT),
		.tick(TIMER_TICK), .ovf, .conv_count
	);

	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	task automatic chk(input string nm, input logic [33:0] e,
			input logic [33:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic finish_test();
		if (fail_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic give_up();
		fail_count++;
		$display("[ERR] wait expected done seen timeout");
		finish_test();
	endtask

	function automatic logic [33:0] okv(input logic [7:0] d);
		return {RESP_OKAY, 24'h0, d};
	endfunction

	// Oldest note is matched against each response as it appears
	always @(posedge CLK) begin
		if (RVALID && RREADY)
			chk("read", rd_q.pop_front(), {RRESP, RDATA});
		if (BVALID && BREADY)
			chk("bresp", 34'(wr_q.pop_front()), 34'(BRESP));
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d,
			input logic [3:0] s, input logic [1:0] r);
		int n;
		wr_q.push_back(r);
		AWADDR <= a;
		WDATA <= {24'h0, d};
		WSTRB <= s;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge CLK);
			if (AWREADY)
				AWVALID <= 1'b0;
			if (WREADY)
				WVALID <= 1'b0;
			if (BVALID)
				break;
		end
		BREADY <= 1'b0;
		if (n == 50)
			give_up();
		// Let an edge pass before the next request
		@(posedge CLK);
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		int n;
		rd_q.push_back(e);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge CLK);
			if (ARREADY)
				ARVALID <= 1'b0;
			if (RVALID)
				break;
		end
		RREADY <= 1'b0;
		if (n == 50)
			give_up();
		@(posedge CLK);
	endtask

	task automatic ld(input logic [15:0] v);
		load <= 1'b1;
		load_val <= v;
		@(posedge CLK);
		load <= 1'b0;
		@(posedge CLK);
	endtask

	initial begin
		{RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
		{CONV_ON, load, PIN_SEL, hold, WSTRB} = '0;
		{AWADDR, ARADDR, WDATA, load_val} = '0;
		fail_count = 0;
		compares = 0;
		void'($urandom(29049));
		repeat (6) @(posedge CLK);
		RESET_N <= 1'b1;
		repeat (2) @(posedge CLK);
		rd(8'h6c, okv(8'h00));
		for (int k = 0; k < 4; k++) begin
			wr(reg_a[k], 8'hff, 4'h1, RESP_OKAY);
			rd(reg_a[k], okv(reg_m[k]));
			wr(reg_a[k], 8'h00, 4'h1, RESP_OKAY);
		end
		wr(8'h08, 8'h55, 4'h0, RESP_OKAY);
		rd(8'h08, okv(8'h00));
		rd(8'h70, {RESP_SLVERR, 32'h0});
		wr(8'h74, 8'h01, 4'h1, RESP_SLVERR);
		// Every compare mode on unit 1, timer 0, random match value
		for (int k = 0; k < 5; k++) begin
			m = {8'h01, 8'h10 + 8'($urandom % 32)};
			ld(16'h0000);
			wr(8'h68, 8'h1f, 4'h1, RESP_OKAY);
			wr(8'h20, m[7:0], 4'h1, RESP_OKAY);
			wr(8'h40, m[15:8], 4'h1, RESP_OKAY);
			wr(8'h00, {4'h0, modes[k]}, 4'h1, RESP_OKAY);
			repeat (2) @(posedge CLK);
			chk("oe", 34'(k < 3), 34'(CMP_OE_PRI[0]));
			ld(m - 16'h0003);
			for (i = 0; i < 100 && TIMER_COUNT[0] != m + 16'h1
					&& TIMER_COUNT[0] != 16'h0; i++)
				@(posedge CLK);
			if (i == 100)
				give_up();
			chk("count", (k == 4) ? 34'h0 : 34'(m + 16'h1),
				34'(TIMER_COUNT[0]));
			chk("pin", 34'(exp_out[k]), 34'(CMP_OUT[0]));
			rd(8'h6c, okv({7'h0, exp_out[k]}));
			rd(8'h68, okv(8'h01));
			chk("ovf", 34'h0, 34'(ovf[0]));
		end
		wr(8'h00, 8'h00, 4'h1, RESP_OKAY);
		rd(8'h6c, okv(8'h00));
		wr(8'h04, {4'h0, MODE_SET}, 4'h1, RESP_OKAY);
		PIN_SEL <= 2'b01;
		repeat (3) @(posedge CLK);
		chk("oe_alt", 34'h1, 34'(CMP_OE_ALT));
		chk("oe_pri", 34'h0, 34'(CMP_OE_PRI[1]));
		PIN_SEL <= 2'b00;
		repeat (3) @(posedge CLK);
		chk("oe_alt", 34'h0, 34'(CMP_OE_ALT));
		chk("oe_pri", 34'h1, 34'(CMP_OE_PRI[1]));
		wr(8'h04, 8'h00, 4'h1, RESP_OKAY);
		// Unit 5 on timer 1 counting 0x0000 to 0x0010 with conversions
		wr(8'h64, 8'h04, 4'h1, RESP_OKAY);
		wr(8'h30, 8'h10, 4'h1, RESP_OKAY);
		wr(8'h50, 8'h00, 4'h1, RESP_OKAY);
		CONV_ON <= 1'b1;
		ld(16'h0000);
		wr(8'h68, 8'h1f, 4'h1, RESP_OKAY);
		wr(8'h10, {4'h0, MODE_SPECIAL}, 4'h1, RESP_OKAY);
		base = conv_count;
		peak = 16'h0;
		for (i = 0; i < 400 && conv_count - base < 3; i++) begin
			@(posedge CLK);
			if (TIMER_COUNT[1] > peak)
				peak = TIMER_COUNT[1];
		end
		chk("starts", 34'h3, 34'(conv_count - base));
		chk("peak", 34'h10, 34'(peak));
		chk("ovf", 34'h0, 34'(ovf[1]));
		chk("oe_pri", 34'h0, 34'(CMP_OE_PRI[4]));
		rd(8'h68, okv(8'h10));
		CONV_ON <= 1'b0;
		base = conv_count;
		repeat (150) @(posedge CLK);
		chk("starts", 34'h0, 34'(conv_count - base));
		wr(8'h10, 8'h00, 4'h1, RESP_OKAY);
		// Unit 4 on timer 2: match rewritten while the clear waits
		wr(8'h64, 8'h02, 4'h1, RESP_OKAY);
		wr(8'h2c, 8'h40, 4'h1, RESP_OKAY);
		wr(8'h4c, 8'h00, 4'h1, RESP_OKAY);
		wr(8'h0c, {4'h0, MODE_SPECIAL}, 4'h1, RESP_OKAY);
		ld(16'h003c);
		for (i = 0; i < 100 && TIMER_COUNT[2] != 16'h0040; i++)
			@(posedge CLK);
		if (i == 100)
			give_up();
		hold <= 3'b100;
		for (i = 0; i < 10 && TIMER_CLEAR[2] !== 1'b1; i++)
			@(posedge CLK);
		if (i == 10)
			give_up();
		chk("count", 34'h40, 34'(TIMER_COUNT[2]));
		wr(8'h2c, 8'h50, 4'h1, RESP_OKAY);
		repeat (2) @(posedge CLK);
		chk("clear", 34'h0, 34'(TIMER_CLEAR[2]));
		hold <= 3'b000;
		for (i = 0; i < 20 && TIMER_COUNT[2] == 16'h0040; i++)
			@(posedge CLK);
		chk("count", 34'h41, 34'(TIMER_COUNT[2]));
		finish_test();
	end
endmodule

`default_nettype wire
